// File: cpexc_cfg.svh
/*
 * Constants for the exception and configuration register bank:
 * register/select numbers, field positions, reset values, codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CPEXC_CFG_SVH
`define CPEXC_CFG_SVH

// ****************************************
// Register and select numbers
// ****************************************
`define CPEXC_REG_ERA 5'd14
`define CPEXC_SEL_ERA 3'd0
`define CPEXC_REG_PRI 5'd15
`define CPEXC_SEL_PRI 3'd0
`define CPEXC_SEL_EVB 3'd1
`define CPEXC_REG_CFG 5'd16
`define CPEXC_SEL_CFG0 3'd0
`define CPEXC_SEL_CFG1 3'd1
`define CPEXC_SEL_CFG2 3'd2
`define CPEXC_SEL_CFG3 3'd3

// ****************************************
// Exception codes
// ****************************************
`define CPEXC_CODE_DBG_INSTR 5'h13
`define CPEXC_CODE_DBG_STORE 5'h14
`define CPEXC_CODE_DBG_LOAD 5'h15
`define CPEXC_CODE_DBG_BREAK 5'h1a
`define CPEXC_CODE_DBG_INTR 5'h1b
`define CPEXC_CODE_DBG_STEP 5'h1c

// ****************************************
// Revision identification (values arbitrary)
// ****************************************
`define CPEXC_IMPL_NUM 8'h5a
`define CPEXC_REV_MAJOR 4'h1
`define CPEXC_REV_MINOR 4'h0

// ****************************************
// Vector base layout
// ****************************************
`define CPEXC_EVB_BASE_LSB 12
`define CPEXC_EVB_BASE_MSB 29
`define CPEXC_EVB_CORE_W 10
`define CPEXC_EVB_RESET 18'h00000

// ****************************************
// Configuration reset values
// ****************************************
`define CPEXC_CFG0_RESET 32'h00030932
`define CPEXC_CFG0_SW_MSB 2
`define CPEXC_CFG1_RESET 32'hbe63318a
`define CPEXC_CFG2_RESET 32'h80001643
`define CPEXC_CFG3_RESET 32'h000000a0

`endif

// File: cpexc_code_map.sv
/*
 * Debug exception kind to exception code encoder.
 * Assumes a registered consumer; purely combinational.
 */
`include "cpexc_cfg.svh"

module cpexc_code_map (
    // Kind in
    input wire cpexc_pkg::cpexc_dbg_t kind,
    // Code out
    output logic [4:0] code,
    output logic code_valid
);

    // Code lookup
    always_comb begin
        code = 5'h00;
        code_valid = 1'b1;
        case (kind)
            cpexc_pkg::CPEXC_DBG_INSTR: code = `CPEXC_CODE_DBG_INSTR;
            cpexc_pkg::CPEXC_DBG_STORE: code = `CPEXC_CODE_DBG_STORE;
            cpexc_pkg::CPEXC_DBG_LOAD: code = `CPEXC_CODE_DBG_LOAD;
            cpexc_pkg::CPEXC_DBG_BREAK: code = `CPEXC_CODE_DBG_BREAK;
            cpexc_pkg::CPEXC_DBG_INTR: code = `CPEXC_CODE_DBG_INTR;
            cpexc_pkg::CPEXC_DBG_STEP: code = `CPEXC_CODE_DBG_STEP;
            default: code_valid = 1'b0;
        endcase
    end

endmodule // cpexc_code_map

// File: cpexc_pkg.sv
/*
 * Types for the exception and configuration register bank.
 * Assumes cpexc_cfg.svh is compiled alongside.
 */
package cpexc_pkg;

    // Register access request from the pipeline
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] regnum;
        logic [2:0] sel;
        logic [63:0] wdata;
    } cpexc_acc_t;

    // Exception event from the pipeline
    typedef struct packed {
        logic valid;
        logic sync;
        logic in_delay_slot;
        logic no_level;
        logic [63:0] pc;
        logic [63:0] branch_pc;
    } cpexc_exc_t;

    // Kinds of debug exception
    typedef enum logic [2:0] {
        CPEXC_DBG_INSTR,
        CPEXC_DBG_STORE,
        CPEXC_DBG_LOAD,
        CPEXC_DBG_BREAK,
        CPEXC_DBG_INTR,
        CPEXC_DBG_STEP,
        CPEXC_DBG_NONE
    } cpexc_dbg_t;

    // Access handshake phase
    typedef enum logic {
        CPEXC_IDLE,
        CPEXC_DONE
    } cpexc_state_t;

endpackage

// File: cpexc_regs.sv
/*
 * Exception reporting and configuration register bank of a 64-bit core:
 * return address, revision ident, vector base, four configuration words.
 * Assumes the pipeline issues register moves and exception events
 * synchronous to ref_clk, one access at a time.
 */
// Operation
// - Debug instr/store/load codes 19, 20, 21
// - Breakpoint, interrupt, single-step codes 26-28
// - Return address: faulting pc or branch
// - No return address update when level set
// - Revision ident read-only, fields, zeros above
// - Revision byte: major high, minor low nibble
// - Writable vector base, fixed one, zeros
// - Read-only core index in vector base
// - Config bits 31..3 hardware, read-only
// - Config bits 2..0 software writable
// - Config resets to documented value
// - Architecture kind codes 0, 1, 2
// - Kernel segment cacheability codes 2, 3
// - Endianness flag 1 big, 0 little
// - Translation entries reported minus one
// - Line size codes 0 none, 1-6
// - Ways code n means n+1 ways
// - Feature flags one when implemented
// - Secondary cache config read-only, reset value
// - Secondary config bit 31 reads one
// - Extension config read-only, reset value
// - Set level flag on ordinary exceptions
`include "cpexc_cfg.svh"

module cpexc_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register access
    input wire cpexc_pkg::cpexc_acc_t acc,
    input wire logic [`CPEXC_EVB_CORE_W-1:0] core_index,
    // Exception events
    input wire cpexc_pkg::cpexc_exc_t exc,
    input wire logic level_clear,
    input wire cpexc_pkg::cpexc_dbg_t dbg_kind,
    // Read answer
    output logic [63:0] rdata,
    output logic rvalid,
    // Status towards the pipeline
    output logic exception_level_flag,
    output logic delay_slot_flag,
    output logic [63:0] exception_return_address,
    output logic [31:0] vector_base_addr,
    output logic [4:0] debug_exc_code,
    output logic debug_code_valid,
    output logic [1:0] kernel_seg_cacheability
);

    // ****************************************
    // Storage
    // ****************************************
    logic [63:0] era_reg;
    logic era_next_en;
    logic [63:0] era_next;
    logic level_reg;
    logic bd_reg;
    logic [`CPEXC_EVB_BASE_MSB:`CPEXC_EVB_BASE_LSB] evb_reg;
    logic [`CPEXC_EVB_CORE_W-1:0] core_reg;
    logic [`CPEXC_CFG0_SW_MSB:0] cfg0_sw_reg;
    logic [63:0] rdata_next;
    logic [4:0] code_c;
    logic code_v_c;
    cpexc_pkg::cpexc_state_t state_reg;

    // Register select decode, used by reads and writes
    function automatic logic hit(input logic [4:0] r, input logic [2:0] s,
                                 input logic [4:0] rr, input logic [2:0] ss);
        hit = (r == rr) && (s == ss);
    endfunction

    // ****************************************
    // Return address and level flag
    // ****************************************

    // Choose faulting pc or preceding branch
    always_comb begin
        era_next_en = 1'b0;
        era_next = era_reg;
        if (exc.valid && exc.sync && !level_reg) begin
            era_next_en = 1'b1;
            era_next = exc.in_delay_slot ? exc.branch_pc : exc.pc;
        end else if (acc.wr && hit(acc.regnum, acc.sel, `CPEXC_REG_ERA,
                                   `CPEXC_SEL_ERA)) begin
            era_next_en = 1'b1;
            era_next = acc.wdata;
        end
    end

    // Return address register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            era_reg <= 64'h0000000000000000;
        end else if (era_next_en) begin
            era_reg <= era_next;
        end
    end

    // Delay-slot flag follows the captured address
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bd_reg <= 1'b0;
        end else if (exc.valid && exc.sync && !level_reg) begin
            bd_reg <= exc.in_delay_slot;
        end
    end

    // Level flag: exception set wins over clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_reg <= 1'b0;
        end else if (exc.valid && !exc.no_level) begin
            level_reg <= 1'b1;
        end else if (level_clear) begin
            level_reg <= 1'b0;
        end
    end

    // ****************************************
    // Vector base
    // ****************************************

    // Writable base; core index resampled on every clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evb_reg <= `CPEXC_EVB_RESET;
        end else if (acc.wr && hit(acc.regnum, acc.sel, `CPEXC_REG_PRI,
                                   `CPEXC_SEL_EVB)) begin
            evb_reg <= acc.wdata[`CPEXC_EVB_BASE_MSB:`CPEXC_EVB_BASE_LSB];
        end
    end

    // Core index is read-only to software
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_index;
        end
    end

    // ****************************************
    // Configuration
    // ****************************************

    // Only the low three bits take writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg0_sw_reg <= 3'(`CPEXC_CFG0_RESET & 32'h00000007);
        end else if (acc.wr && hit(acc.regnum, acc.sel, `CPEXC_REG_CFG,
                                   `CPEXC_SEL_CFG0)) begin
            cfg0_sw_reg <= acc.wdata[`CPEXC_CFG0_SW_MSB:0];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************

    // Read data assembly; read-only words are constants
    always_comb begin
        rdata_next = 64'h0000000000000000;
        if (hit(acc.regnum, acc.sel, `CPEXC_REG_ERA, `CPEXC_SEL_ERA)) begin
            rdata_next = era_reg;
        end else if (hit(acc.regnum, acc.sel, `CPEXC_REG_PRI, `CPEXC_SEL_PRI)) begin
            rdata_next = {48'h000000000000, `CPEXC_IMPL_NUM,
                          `CPEXC_REV_MAJOR, `CPEXC_REV_MINOR};
        end else if (hit(acc.regnum, acc.sel, `CPEXC_REG_PRI, `CPEXC_SEL_EVB)) begin
            rdata_next = {32'h00000000, 2'b10, evb_reg, 2'b00, core_reg};
        end else if (hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG0)) begin
            rdata_next = {32'h00000000,
                          `CPEXC_CFG0_RESET & 32'hfffffff8};
            rdata_next[2:0] = cfg0_sw_reg;
        end else if (hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG1)) begin
            rdata_next = {32'h00000000, `CPEXC_CFG1_RESET};
        end else if (hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG2)) begin
            rdata_next = {32'h00000000, `CPEXC_CFG2_RESET};
        end else if (hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG3)) begin
            rdata_next = {32'h00000000, `CPEXC_CFG3_RESET};
        end
    end

    // Read answer one cycle after request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 64'h0000000000000000;
            rvalid <= 1'b0;
            state_reg <= cpexc_pkg::CPEXC_IDLE;
        end else begin
            rvalid <= acc.rd;
            if (acc.rd) begin
                rdata <= rdata_next;
            end
            case (state_reg)
                cpexc_pkg::CPEXC_IDLE: begin
                    if (acc.rd) begin
                        state_reg <= cpexc_pkg::CPEXC_DONE;
                    end
                end
                cpexc_pkg::CPEXC_DONE: begin
                    if (!acc.rd) begin
                        state_reg <= cpexc_pkg::CPEXC_IDLE;
                    end
                end
                default: state_reg <= cpexc_pkg::CPEXC_IDLE;
            endcase
        end
    end

    // ****************************************
    // Debug code and status outputs
    // ****************************************
    cpexc_code_map u_code_map (
        .kind(dbg_kind),
        .code(code_c),
        .code_valid(code_v_c)
    );

    // Registered status outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            exception_level_flag <= 1'b0;
            delay_slot_flag <= 1'b0;
            exception_return_address <= 64'h0000000000000000;
            vector_base_addr <= 32'h80000000;
            debug_exc_code <= 5'h00;
            debug_code_valid <= 1'b0;
            kernel_seg_cacheability <= 2'h0;
        end else begin
            exception_level_flag <= level_reg;
            delay_slot_flag <= bd_reg;
            exception_return_address <= era_reg;
            vector_base_addr <= {2'b10, evb_reg, 12'h000};
            debug_exc_code <= code_c;
            debug_code_valid <= code_v_c;
            kernel_seg_cacheability <= cfg0_sw_reg[1:0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_ERA_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        level_reg && !(acc.wr && hit(acc.regnum, acc.sel, `CPEXC_REG_ERA,
        `CPEXC_SEL_ERA)) |=> $stable(era_reg))
        else $error("return address changed while level flag set");
    AST_ERA_SLOT: assert property (@(posedge ref_clk) disable iff (rst)
        exc.valid && exc.sync && !level_reg && exc.in_delay_slot
        |=> era_reg == $past(exc.branch_pc) && bd_reg)
        else $error("delay slot capture wrong");
    AST_ERA_PC: assert property (@(posedge ref_clk) disable iff (rst)
        exc.valid && exc.sync && !level_reg && !exc.in_delay_slot
        |=> era_reg == $past(exc.pc) && !bd_reg)
        else $error("faulting pc capture wrong");
    AST_LEVEL_SET: assert property (@(posedge ref_clk) disable iff (rst)
        exc.valid && !exc.no_level |=> level_reg ##1 exception_level_flag)
        else $error("level flag not set");
    AST_PRI_READ: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_PRI, `CPEXC_SEL_PRI)
        |=> rvalid && rdata[63:16] == 48'h0 && rdata[15:8] == `CPEXC_IMPL_NUM)
        else $error("revision ident read wrong");
    AST_CFG2_READ: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG2)
        |=> rdata[31] && rdata[31:0] == 32'h80001643)
        else $error("secondary config read wrong");
    AST_CFG0_RO: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG0)
        |=> rdata[31:3] == 29'h00006126)
        else $error("config high bits changed");
    AST_EVB_FIXED: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_PRI, `CPEXC_SEL_EVB)
        |=> rdata[31:30] == 2'b10 && rdata[11:10] == 2'b00)
        else $error("vector base fixed bits wrong");
    AST_DBG_CODE: assert property (@(posedge ref_clk) disable iff (rst)
        dbg_kind == cpexc_pkg::CPEXC_DBG_STEP |=> debug_exc_code == 5'h1c)
        else $error("single-step code wrong");
    AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        !acc.rd
        |=> !rvalid && state_reg == cpexc_pkg::CPEXC_IDLE)
        else $error("answer without read request");
    AST_CFG1_READ: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG1)
        |=> rvalid && rdata == {32'h00000000, `CPEXC_CFG1_RESET})
        else $error("primary cache config read wrong");
    AST_CFG3_READ: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG3)
        |=> rvalid && rdata == {32'h00000000, `CPEXC_CFG3_RESET})
        else $error("extension config read wrong");
    AST_CFG0_SW: assert property (@(posedge ref_clk) disable iff (rst)
        acc.wr && hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG0)
        |=> cfg0_sw_reg == $past(acc.wdata[`CPEXC_CFG0_SW_MSB:0]))
        else $error("config low bits write lost");
    AST_CFG0_LOW: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_CFG, `CPEXC_SEL_CFG0)
        |=> rdata[2:0] == $past(cfg0_sw_reg))
        else $error("config low bits read wrong");
    AST_EVB_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        acc.wr && hit(acc.regnum, acc.sel, `CPEXC_REG_PRI, `CPEXC_SEL_EVB)
        |=> evb_reg == $past(acc.wdata[`CPEXC_EVB_BASE_MSB:`CPEXC_EVB_BASE_LSB]))
        else $error("vector base write lost");
    AST_CORE_RO: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_PRI, `CPEXC_SEL_EVB)
        |=> rdata[`CPEXC_EVB_CORE_W-1:0] == $past(core_index, 2))
        else $error("core index read wrong");
    AST_LEVEL_NOSET: assert property (@(posedge ref_clk) disable iff (rst)
        exc.valid && exc.no_level && !level_reg
        |=> !level_reg)
        else $error("level flag set by reset-class event");
    AST_SLOT_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        exc.valid && level_reg
        |=> $stable(bd_reg))
        else $error("delay-slot flag changed while level flag set");
    AST_DBG_INSTR: assert property (@(posedge ref_clk) disable iff (rst)
        dbg_kind == cpexc_pkg::CPEXC_DBG_INSTR
        |=> debug_exc_code == 5'h13 && debug_code_valid)
        else $error("debug instruction code wrong");
    AST_DBG_STORE: assert property (@(posedge ref_clk) disable iff (rst)
        dbg_kind == cpexc_pkg::CPEXC_DBG_STORE
        |=> debug_exc_code == 5'h14 && debug_code_valid)
        else $error("debug store code wrong");
    AST_DBG_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
        dbg_kind == cpexc_pkg::CPEXC_DBG_LOAD
        |=> debug_exc_code == 5'h15 && debug_code_valid)
        else $error("debug load code wrong");
    AST_DBG_BREAK: assert property (@(posedge ref_clk) disable iff (rst)
        dbg_kind == cpexc_pkg::CPEXC_DBG_BREAK
        |=> debug_exc_code == 5'h1a && debug_code_valid)
        else $error("debug breakpoint code wrong");
    AST_DBG_INTR: assert property (@(posedge ref_clk) disable iff (rst)
        dbg_kind == cpexc_pkg::CPEXC_DBG_INTR
        |=> debug_exc_code == 5'h1b && debug_code_valid)
        else $error("debug interrupt code wrong");
    AST_PRI_REV: assert property (@(posedge ref_clk) disable iff (rst)
        acc.rd && hit(acc.regnum, acc.sel, `CPEXC_REG_PRI, `CPEXC_SEL_PRI)
        |=> rdata[7:4] == `CPEXC_REV_MAJOR && rdata[3:0] == `CPEXC_REV_MINOR)
        else $error("revision byte layout wrong");

endmodule // cpexc_regs

// File: tb_top.sv
/*
 * Self-checking bench for the exception and configuration register bank.
 * Assumes cpexc_pkg and cpexc_cfg.svh compiled first; inputs driven on the
 * falling edge of a 40 MHz ref_clk, read answers checked from a queue.
 */
`include "cpexc_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals
    // ****************************************
    logic ref_clk;
    logic rst;
    cpexc_pkg::cpexc_acc_t acc;
    logic [`CPEXC_EVB_CORE_W-1:0] core_idx;
    cpexc_pkg::cpexc_exc_t exc;
    logic level_clear;
    cpexc_pkg::cpexc_dbg_t dbg_kind;
    logic [63:0] rdata;
    logic rvalid;
    logic exception_level_flag;
    logic delay_slot_flag;
    logic [63:0] exception_return_address;
    logic [31:0] vector_base_addr;
    logic [4:0] debug_exc_code;
    logic debug_code_valid;
    logic [1:0] kernel_seg_cacheability;
    int errors;
    int cmp_count;
    logic [63:0] rd_q[$];
    logic [4:0] dbg_q[$];
    logic [63:0] w;
    logic [63:0] pa;
    logic [63:0] pb;

    // Device under test
    cpexc_regs uut (
        .ref_clk(ref_clk),
        .rst(rst),
        .acc(acc),
        .core_index(core_idx),
        .exc(exc),
        .level_clear(level_clear),
        .dbg_kind(dbg_kind),
        .rdata(rdata),
        .rvalid(rvalid),
        .exception_level_flag(exception_level_flag),
        .delay_slot_flag(delay_slot_flag),
        .exception_return_address(exception_return_address),
        .vector_base_addr(vector_base_addr),
        .debug_exc_code(debug_exc_code),
        .debug_code_valid(debug_code_valid),
        .kernel_seg_cacheability(kernel_seg_cacheability)
    );

    // Clock, 25 ns period
    always #12.5 ref_clk = ~ref_clk;

    // ****************************************
    // Tasks
    // ****************************************
    // Compare and count
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Read request, answer noted for the monitor
    task automatic rd(input logic [4:0] r, input logic [2:0] s, input logic [63:0] exp);
        @(negedge ref_clk);
        acc = '{rd: 1'b1, wr: 1'b0, regnum: r, sel: s, wdata: 64'h0};
        rd_q.push_back(exp);
    endtask

    // Write request
    task automatic wr(input logic [4:0] r, input logic [2:0] s, input logic [63:0] d);
        @(negedge ref_clk);
        acc = '{rd: 1'b0, wr: 1'b1, regnum: r, sel: s, wdata: d};
    endtask

    // Drop requests, then idle
    task automatic idle(input int n);
        @(negedge ref_clk);
        acc = '0;
        repeat (n) @(negedge ref_clk);
    endtask

    // One-cycle exception event
    task automatic raise(input logic slot, input logic nl, input logic sy, input logic [63:0] p,
                         input logic [63:0] b);
        @(negedge ref_clk);
        exc = '{valid: 1'b1, sync: sy, in_delay_slot: slot, no_level: nl, pc: p, branch_pc: b};
        @(negedge ref_clk);
        exc.valid = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    // One-cycle level clear
    task automatic clear_level();
        @(negedge ref_clk);
        level_clear = 1'b1;
        @(negedge ref_clk);
        level_clear = 1'b0;
    endtask

    // Read-only words after reset or after writes
    task automatic ro_reads();
        rd(5'd16, 3'd1, {32'h0, `CPEXC_CFG1_RESET});
        rd(5'd16, 3'd2, 64'h80001643);
        rd(5'd16, 3'd3, 64'h000000a0);
        rd(5'd15, 3'd0, {48'h0, `CPEXC_IMPL_NUM, `CPEXC_REV_MAJOR, `CPEXC_REV_MINOR});
        idle(2);
    endtask

    // ****************************************
    // Monitors
    // ****************************************
    // Read answers against the oldest note
    always @(negedge ref_clk) begin
        if (rvalid === 1'b1) begin
            if (rd_q.size() == 0) begin
                chk("unexpected_rvalid", 64'h1, 64'h0);
            end else begin
                chk("rdata", rdata, rd_q.pop_front());
            end
        end
        if (debug_code_valid === 1'b1) begin
            if (dbg_q.size() == 0) begin
                chk("unexpected_code", 64'h1, 64'h0);
            end else begin
                chk("debug_exc_code", {59'h0, debug_exc_code}, {59'h0, dbg_q.pop_front()});
            end
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [4:0] codes[6];
        codes = '{5'd19, 5'd20, 5'd21, 5'd26, 5'd27, 5'd28};
        ref_clk = 1'b0;
        rst = 1'b1;
        acc = '0;
        exc = '0;
        level_clear = 1'b0;
        dbg_kind = cpexc_pkg::CPEXC_DBG_NONE;
        errors = 0;
        cmp_count = 0;
        void'($urandom(32'h83ac));
        core_idx = `CPEXC_EVB_CORE_W'($urandom());
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk("vec_base_rst", {32'h0, vector_base_addr}, 64'h80000000);
        // Reset values, unmapped read
        rd(5'd16, 3'd0, 64'h00030932);
        rd(5'd15, 3'd1, {32'h0, 2'b10, 18'h0, 2'b00, core_idx});
        rd(5'd14, 3'd0, 64'h0);
        rd(5'd3, 3'd0, 64'h0);
        ro_reads();
        // Writes to read-only words are ignored
        wr(5'd16, 3'd1, '1);
        wr(5'd16, 3'd2, '1);
        wr(5'd16, 3'd3, '1);
        wr(5'd15, 3'd0, '1);
        ro_reads();
        // Config: low three bits writable, the rest fixed
        w = {$urandom(), $urandom()};
        wr(5'd16, 3'd0, w);
        rd(5'd16, 3'd0, {32'h0, 29'(32'h00030932 >> 3), w[2:0]});
        idle(2);
        chk("kseg", {62'h0, kernel_seg_cacheability}, {62'h0, w[1:0]});
        // Vector base: base writable, fixed bits and core index kept
        w = {$urandom(), $urandom()};
        wr(5'd15, 3'd1, w);
        rd(5'd15, 3'd1, {32'h0, 2'b10, w[29:12], 2'b00, core_idx});
        idle(1);
        chk("vec_base", {32'h0, vector_base_addr}, {32'h0, 2'b10, w[29:12], 12'h000});
        // Return address software write
        w = {$urandom(), $urandom()};
        wr(5'd14, 3'd0, w);
        rd(5'd14, 3'd0, w);
        idle(2);
        // Synchronous exception outside a delay slot
        pa = {$urandom(), $urandom()};
        pb = {$urandom(), $urandom()};
        raise(1'b0, 1'b0, 1'b1, pa, pb);
        chk("level", {63'h0, exception_level_flag}, 64'h1);
        chk("era", exception_return_address, pa);
        chk("slot_flag", {63'h0, delay_slot_flag}, 64'h0);
        // Nested exception leaves the return address alone
        raise(1'b1, 1'b0, 1'b1, ~pa, ~pb);
        chk("era_nested", exception_return_address, pa);
        rd(5'd14, 3'd0, pa);
        idle(2);
        // Exception in a delay slot reports the branch
        clear_level();
        raise(1'b1, 1'b0, 1'b1, pa, pb);
        chk("era_slot", exception_return_address, pb);
        chk("slot_flag_br", {63'h0, delay_slot_flag}, 64'h1);
        // Reset-class exception does not raise the level
        clear_level();
        raise(1'b0, 1'b1, 1'b0, pa, pb);
        chk("level_nl", {63'h0, exception_level_flag}, 64'h0);
        // Asynchronous exception raises the level, keeps the address
        raise(1'b0, 1'b0, 1'b0, ~pa, ~pb);
        chk("level_async", {63'h0, exception_level_flag}, 64'h1);
        chk("era_async", exception_return_address, pb);
        chk("slot_flag_async", {63'h0, delay_slot_flag}, 64'h1);
        // Every debug exception kind
        for (int i = 0; i < 6; i++) begin
            @(negedge ref_clk);
            dbg_kind = cpexc_pkg::cpexc_dbg_t'(i);
            dbg_q.push_back(codes[i]);
            @(negedge ref_clk);
            dbg_kind = cpexc_pkg::CPEXC_DBG_NONE;
        end
        // Bounded drain of outstanding notes
        for (int i = 0; i < 20 && (rd_q.size() > 0 || dbg_q.size() > 0); i++) begin
            @(negedge ref_clk);
        end
        if (rd_q.size() > 0 || dbg_q.size() > 0) begin
            errors++;
            $display("MISMATCH drain expected 0 seen %0d", rd_q.size() + dbg_q.size());
        end
        test_done();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        test_done();
    end

endmodule // tb_top
